// ### design/eeec_defs.svh
// Constants of the external edge event controller: sizes, offsets, resets.
`ifndef EEEC_DEFS_SVH
`define EEEC_DEFS_SVH

// Line counts and widths.
`define EEEC_NUM_LINES     19
`define EEEC_NUM_EXT       16
`define EEEC_NUM_PINS      80
`define EEEC_SEL_W         7
`define EEEC_ADDR_W        12
`define EEEC_DATA_W        32

// Internal source line positions.
`define EEEC_LINE_SVD      16
`define EEEC_LINE_RTC      17
`define EEEC_LINE_USB      18

// Register byte offsets.
`define EEEC_OFF_INT_MASK  12'h000
`define EEEC_OFF_EVT_MASK  12'h004
`define EEEC_OFF_RISE_EN   12'h008
`define EEEC_OFF_FALL_EN   12'h00c
`define EEEC_OFF_SW_TRIG   12'h010
`define EEEC_OFF_PENDING   12'h014
`define EEEC_OFF_SEL_BASE  12'h020
`define EEEC_OFF_SEL_LAST  12'h02c

// Field layout of a pin select word: four 8-bit slots, 7 bits used.
`define EEEC_SEL_SLOT_W    8
`define EEEC_SEL_PER_WORD  4

// Reset values.
`define EEEC_RST_LINES     19'h0_0000
`define EEEC_RST_SEL       7'h7f
`define EEEC_RST_DATA      32'h0000_0000

`endif

// ### design/eeec_edge.sv
// One edge detector line that catches pulses shorter than a clock period.
`timescale 1ns/1ps

module eeec_edge
    import eeec_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    eeec_edge_if.det  port
);

    logic rise_tog;
    logic fall_tog;
    logic rise_s1;
    logic rise_s2;
    logic rise_last;
    logic fall_s1;
    logic fall_s2;
    logic fall_last;

    ////////////////////////////////////////////////////////////////////////
    // The line itself clocks a toggle, so no edge needs a clock edge.
    always_ff @(posedge port.line or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rise_tog <= 1'b0;
        end else begin
            rise_tog <= ~rise_tog;
        end
    end

    always_ff @(negedge port.line or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fall_tog <= 1'b0;
        end else begin
            fall_tog <= ~fall_tog;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers and toggle comparison.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rise_s1   <= 1'b0;
            rise_s2   <= 1'b0;
            rise_last <= 1'b0;
            fall_s1   <= 1'b0;
            fall_s2   <= 1'b0;
            fall_last <= 1'b0;
        end else begin
            rise_s1   <= rise_tog;
            rise_s2   <= rise_s1;
            rise_last <= rise_s2;
            fall_s1   <= fall_tog;
            fall_s2   <= fall_s1;
            fall_last <= fall_s2;
        end
    end

    assign port.rise = rise_s2 ^ rise_last;
    assign port.fall = fall_s2 ^ fall_last;

endmodule

// ### design/eeec_edge_if.sv
// Carrier between the controller core and one edge detector line.
`timescale 1ns/1ps

interface eeec_edge_if;
    logic line;
    logic rise;
    logic fall;

    modport det (
        input  line,
        output rise,
        output fall
    );
    modport ctl (
        output line,
        input  rise,
        input  fall
    );
endinterface

// ### design/eeec_pkg.sv
// Types shared by the external edge event controller modules.
package eeec_pkg;
`include "eeec_defs.svh"

    typedef logic [`EEEC_NUM_LINES-1:0] eeec_lines_type;
    typedef logic [`EEEC_SEL_W-1:0]     eeec_sel_type;
    typedef logic [`EEEC_DATA_W-1:0]    eeec_word_type;

endpackage

// ### design/eeec_top.sv
// External edge event controller with APB registers and pin routing.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps

module eeec_top
    import eeec_pkg::*;
#(
    parameter int NUM_PINS = `EEEC_NUM_PINS
)
(
    input  wire logic                    clk_i,
    input  wire logic                    rst_b_i,
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [`EEEC_ADDR_W-1:0] paddr_i,
    input  wire logic [`EEEC_DATA_W-1:0] pwdata_i,
    output      logic [`EEEC_DATA_W-1:0] prdata_o,
    output      logic                    pready_o,
    output      logic                    pslverr_o,
    input  wire logic [NUM_PINS-1:0]     gpio_i,
    input  wire logic                    svd_i,
    input  wire logic                    rtc_alarm_i,
    input  wire logic                    usb_wakeup_i,
    output      logic                    irq_o,
    output      eeec_lines_type          event_o,
    output      logic                    wake_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    eeec_lines_type int_mask;
    eeec_lines_type evt_mask;
    eeec_lines_type rise_en;
    eeec_lines_type fall_en;
    eeec_lines_type sw_trig;
    eeec_lines_type pending;
    eeec_sel_type   pin_sel [`EEEC_NUM_EXT];

    eeec_lines_type line_raw;
    eeec_lines_type rise;
    eeec_lines_type fall;
    eeec_lines_type hit;
    eeec_lines_type clr;
    eeec_lines_type sw_set;
    eeec_lines_type next_pending;
    eeec_lines_type next_sw_trig;
    eeec_word_type  rd_word;
    logic           mapped;
    logic           setup;
    logic           wr;
    logic           is_sel;

    ////////////////////////////////////////////////////////////////////////
    // Bus phase decode.
    assign setup  = psel_i & ~penable_i;
    assign wr     = psel_i & penable_i & pready_o & pwrite_i;
    assign is_sel = (paddr_i >= `EEEC_OFF_SEL_BASE) &&
                    (paddr_i <= `EEEC_OFF_SEL_LAST) &&
                    (paddr_i[1:0] == 2'h0);

    ////////////////////////////////////////////////////////////////////////
    // Read decode and address map check.
    always_comb begin
        rd_word = `EEEC_RST_DATA;
        mapped  = 1'b1;
        if (paddr_i == `EEEC_OFF_INT_MASK) begin
            rd_word[`EEEC_NUM_LINES-1:0] = int_mask;
        end else if (paddr_i == `EEEC_OFF_EVT_MASK) begin
            rd_word[`EEEC_NUM_LINES-1:0] = evt_mask;
        end else if (paddr_i == `EEEC_OFF_RISE_EN) begin
            rd_word[`EEEC_NUM_LINES-1:0] = rise_en;
        end else if (paddr_i == `EEEC_OFF_FALL_EN) begin
            rd_word[`EEEC_NUM_LINES-1:0] = fall_en;
        end else if (paddr_i == `EEEC_OFF_SW_TRIG) begin
            rd_word[`EEEC_NUM_LINES-1:0] = sw_trig;
        end else if (paddr_i == `EEEC_OFF_PENDING) begin
            rd_word[`EEEC_NUM_LINES-1:0] = pending;
        end else if (is_sel) begin
            for (int k = 0; k < `EEEC_SEL_PER_WORD; k++) begin
                rd_word[k*`EEEC_SEL_SLOT_W +: `EEEC_SEL_W] =
                    pin_sel[{paddr_i[3:2], 2'(k)}];
            end
        end else begin
            mapped = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: ready one cycle after setup, so no wait states.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= `EEEC_RST_DATA;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup & ~mapped;
            prdata_o  <= (setup & ~pwrite_i) ? rd_word : `EEEC_RST_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            int_mask <= `EEEC_RST_LINES;
            evt_mask <= `EEEC_RST_LINES;
            rise_en  <= `EEEC_RST_LINES;
            fall_en  <= `EEEC_RST_LINES;
        end else if (wr) begin
            if (paddr_i == `EEEC_OFF_INT_MASK) begin
                int_mask <= pwdata_i[`EEEC_NUM_LINES-1:0];
            end else if (paddr_i == `EEEC_OFF_EVT_MASK) begin
                evt_mask <= pwdata_i[`EEEC_NUM_LINES-1:0];
            end else if (paddr_i == `EEEC_OFF_RISE_EN) begin
                rise_en <= pwdata_i[`EEEC_NUM_LINES-1:0];
            end else if (paddr_i == `EEEC_OFF_FALL_EN) begin
                fall_en <= pwdata_i[`EEEC_NUM_LINES-1:0];
            end
        end
    end

    // Pin select words, four lines to a word.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            for (int n = 0; n < `EEEC_NUM_EXT; n++) begin
                pin_sel[n] <= `EEEC_RST_SEL;
            end
        end else if (wr && is_sel) begin
            for (int n = 0; n < `EEEC_NUM_EXT; n++) begin
                if (paddr_i[3:2] == 2'(n / `EEEC_SEL_PER_WORD)) begin
                    pin_sel[n] <= pwdata_i[(n % `EEEC_SEL_PER_WORD) *
                                  `EEEC_SEL_SLOT_W +: `EEEC_SEL_W];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line sources: routed pins and internal sources.
    always_comb begin
        line_raw = `EEEC_RST_LINES;
        for (int n = 0; n < `EEEC_NUM_EXT; n++) begin
            if (pin_sel[n] < `EEEC_SEL_W'(NUM_PINS)) begin
                line_raw[n] = gpio_i[pin_sel[n]];
            end
        end
        line_raw[`EEEC_LINE_SVD] = svd_i;
        line_raw[`EEEC_LINE_RTC] = rtc_alarm_i;
        line_raw[`EEEC_LINE_USB] = usb_wakeup_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge detector lines.
    for (genvar n = 0; n < `EEEC_NUM_LINES; n++) begin : g_line
        eeec_edge_if eif ();
        assign eif.line = line_raw[n];
        assign rise[n]  = eif.rise;
        assign fall[n]  = eif.fall;
        eeec_edge u_edge (
            .clk_i   (clk_i),
            .rst_b_i (rst_b_i),
            .port    (eif)
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger selection, software trigger and pending state.
    assign clr    = (wr && paddr_i == `EEEC_OFF_PENDING) ?
                    pwdata_i[`EEEC_NUM_LINES-1:0] : `EEEC_RST_LINES;
    assign sw_set = (wr && paddr_i == `EEEC_OFF_SW_TRIG) ?
                    pwdata_i[`EEEC_NUM_LINES-1:0] : `EEEC_RST_LINES;
    assign hit    = (rise & rise_en) | (fall & fall_en) | sw_set;
    assign next_pending = (pending & ~clr) | hit;
    assign next_sw_trig = (sw_trig & ~clr) | sw_set;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pending <= `EEEC_RST_LINES;
            sw_trig <= `EEEC_RST_LINES;
        end else begin
            pending <= next_pending;
            sw_trig <= next_sw_trig;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request outputs.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_o   <= 1'b0;
            event_o <= `EEEC_RST_LINES;
            wake_o  <= 1'b0;
        end else begin
            irq_o   <= |(next_pending & int_mask);
            event_o <= hit & evt_mask;
            wake_o  <= |(hit & (int_mask | evt_mask));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence apb_setup_s;
        psel_i && !penable_i;
    endsequence

    sequence apb_access_s;
        psel_i && penable_i && pready_o;
    endsequence

    irq_level_a: assert property (
        ##1 irq_o == |($past(pending & ~clr | hit) & $past(int_mask)))
        else $error("interrupt output does not follow unmasked pending");

    pend_set_a: assert property (
        (|hit) |=> ((pending & $past(hit)) == $past(hit)))
        else $error("selected edge did not set its pending bit");

    pend_hold_a: assert property (
        ##1 (($past(pending) & ~pending & ~$past(clr)) == '0))
        else $error("pending bit fell without a clear write");

    pend_cause_a: assert property (
        ##1 ((pending & ~$past(pending) &
              ~$past((rise & rise_en) | (fall & fall_en) | sw_set)) == '0))
        else $error("pending bit rose without a selected edge");

    evt_mask_a: assert property (
        ##1 ((event_o & ~$past(evt_mask)) == '0))
        else $error("masked line raised an event request");

    sel_none_a: assert property (
        (pin_sel[0] >= `EEEC_SEL_W'(NUM_PINS)) |-> !line_raw[0])
        else $error("unrouted external line is not held low");

    apb_ready_a: assert property (
        apb_setup_s |=> pready_o ##1 !pready_o || $past(setup))
        else $error("register bus answer is not one cycle after setup");

    apb_drop_a: assert property (
        apb_access_s |=> !pready_o)
        else $error("ready stayed high after the access phase");

    apb_err_a: assert property (
        pslverr_o |-> pready_o)
        else $error("error flag given outside an answer");

    sw_pend_a: assert property (
        (wr && paddr_i == `EEEC_OFF_SW_TRIG && |pwdata_i[18:0])
        |=> (|pending) [*2])
        else $error("software trigger did not leave pending set");

    sequence clr_write_s;
        wr && paddr_i == `EEEC_OFF_PENDING;
    endsequence

    pend_clr_a: assert property (
        clr_write_s |=> ((pending & $past(clr & ~hit)) == '0))
        else $error("pending bit survived its clear write");

    sw_clr_a: assert property (
        clr_write_s |=> ((sw_trig & $past(clr & ~sw_set)) == '0))
        else $error("software trigger bit survived its clear write");

    wake_src_a: assert property (
        ##1 (wake_o == |($past(hit) & $past(int_mask | evt_mask))))
        else $error("wake request does not follow a selected edge");

    evt_pass_a: assert property (
        ##1 ((event_o ^ ($past(hit) & $past(evt_mask))) == '0))
        else $error("event request does not follow its selected edge");

    route_a: assert property (
        (pin_sel[1] < `EEEC_SEL_W'(NUM_PINS)) |->
        (line_raw[1] == gpio_i[pin_sel[1]]))
        else $error("routed external line does not follow its pin");

    cfg_rise_a: assert property (
        (wr && paddr_i == `EEEC_OFF_RISE_EN) |=>
        (rise_en == $past(pwdata_i[`EEEC_NUM_LINES-1:0])))
        else $error("rising edge enable did not take the written value");

    cfg_mask_a: assert property (
        (wr && paddr_i == `EEEC_OFF_INT_MASK) |=>
        (int_mask == $past(pwdata_i[`EEEC_NUM_LINES-1:0])))
        else $error("interrupt mask did not take the written value");

    wr_data_a: assert property (
        (psel_i && !penable_i && pwrite_i) |=> (prdata_o == '0))
        else $error("read data not zero during a write answer");

endmodule

// ### dv/eeec_src_model.sv
// Model of the pins and internal wakeup sources feeding the controller.
`timescale 1ns/1ps

module eeec_src_model #(
    parameter int NUM_PINS = 80
)
(
    output logic [NUM_PINS-1:0] gpio_o,
    output logic                svd_o,
    output logic                rtc_alarm_o,
    output logic                usb_wakeup_o
);
    logic [NUM_PINS+2:0] lvl;

    initial lvl = '0;

    // Pins first, then voltage detector, alarm and wakeup sources.
    assign gpio_o       = lvl[NUM_PINS-1:0];
    assign svd_o        = lvl[NUM_PINS];
    assign rtc_alarm_o  = lvl[NUM_PINS+1];
    assign usb_wakeup_o = lvl[NUM_PINS+2];

    // A pulse of the given width in ns, with no relation to the clock.
    task automatic pulse(input int idx, input real width);
        #2;
        lvl[idx] = ~lvl[idx];
        #(width);
        lvl[idx] = ~lvl[idx];
    endtask

    // A level change placed away from the clock edge.
    task automatic set_lvl(input int idx, input logic v);
        #2;
        lvl[idx] = v;
    endtask
endmodule

// ### dv/tb_eeec_top.sv
// Self-checking bench of the external edge event controller.
`timescale 1ns/1ps
`include "eeec_defs.svh"

module tb_eeec_top
    import eeec_pkg::*;
;
    logic           clk, psel, penable, pwrite;
    logic           rst_b = 1'b1;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata, r;
    logic           pready, pslverr, irq, wake, svd, rtc, usb;
    logic [79:0]    gpio;
    eeec_lines_type event_s;
    logic [32:0]    note;
    logic [32:0]    exp_q[$];
    int             err_total = 0;
    int             checks = 0;
    int             seed = 87;

    eeec_src_model #(.NUM_PINS(80)) i_src (.gpio_o(gpio), .svd_o(svd),
        .rtc_alarm_o(rtc), .usb_wakeup_o(usb));

    eeec_top #(.NUM_PINS(80)) i_dut (.clk_i(clk), .rst_b_i(rst_b),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .gpio_i(gpio),
        .svd_i(svd), .rtc_alarm_i(rtc), .usb_wakeup_i(usb),
        .irq_o(irq), .event_o(event_s), .wake_o(wake));

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task test_done();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // One APB transfer; the expected answer is noted for the monitor.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        int n;
        exp_q.push_back(e);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        chk(33'(n), 33'h0_0000_0001);
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d, 33'h0_0000_0000);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 32'h0000_0000, {1'b0, e});
    endtask

    task automatic chk_irq(input logic e);
        repeat (2) @(posedge clk);
        chk(irq, e);
    endtask

    task automatic wait_evt(input int n, input logic e, input logic wk);
        logic seen, w, wa;
        seen = 0;
        w = 0;
        wa = 0;
        repeat (10) begin
            @(posedge clk);
            if (wake === 1'b1) wa = 1;
            if (event_s[n] === 1'b1) begin
                seen = 1;
                w = wake;
            end
        end
        chk(seen, e);
        if (e) chk(w, wk);
        else chk(wa, wk);
    endtask

    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            note = exp_q.pop_front();
            chk({pslverr, prdata}, note);
        end
    end

    initial begin
        #100us;
        err_total++;
        test_done();
    end

    initial begin
        rst_b <= 1'b0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1;
        for (int i = 0; i < 6; i++) rd(12'(4 * i), 32'h0000_0000);
        for (int i = 0; i < 4; i++)
            rd(12'(`EEEC_OFF_SEL_BASE + 4 * i), 32'h7f7f_7f7f);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            wr(12'(4 * i), r);
            rd(12'(4 * i), r & 32'h0007_ffff);
            wr(12'(4 * i), 32'h0000_0000);
        end
        apb(0, 12'h018, 32'h0000_0000, 33'h1_0000_0000);
        apb(1, 12'h030, 32'hffff_ffff, 33'h1_0000_0000);
        wr(`EEEC_OFF_SEL_BASE, 32'h7f7f_4f25);
        rd(`EEEC_OFF_SEL_BASE, 32'h7f7f_4f25);
        wr(`EEEC_OFF_EVT_MASK, 32'h0007_ffff);
        wr(`EEEC_OFF_RISE_EN, 32'h0007_0001);
        wr(`EEEC_OFF_FALL_EN, 32'h0007_0002);
        // Narrow pulse on pin 37 routed to line 0, interrupt masked.
        i_src.pulse(37, 2.0);
        wait_evt(0, 1, 1);
        rd(`EEEC_OFF_PENDING, 32'h0000_0001);
        chk_irq(0);
        wr(`EEEC_OFF_INT_MASK, 32'h0000_0001);
        chk_irq(1);
        wr(`EEEC_OFF_PENDING, 32'h0000_0001);
        chk_irq(0);
        rd(`EEEC_OFF_PENDING, 32'h0000_0000);
        i_src.pulse(36, 2.0);
        wait_evt(0, 0, 0);
        rd(`EEEC_OFF_PENDING, 32'h0000_0000);
        wr(`EEEC_OFF_EVT_MASK, 32'h0007_fffe);
        i_src.pulse(37, 2.0);
        wait_evt(0, 0, 1);
        chk_irq(1);
        wr(`EEEC_OFF_PENDING, 32'h0000_0001);
        wr(`EEEC_OFF_EVT_MASK, 32'h0007_ffff);
        // Pin 79 on line 1 reacts to falling edges only.
        i_src.set_lvl(79, 1);
        wait_evt(1, 0, 0);
        rd(`EEEC_OFF_PENDING, 32'h0000_0000);
        i_src.set_lvl(79, 0);
        wait_evt(1, 1, 1);
        rd(`EEEC_OFF_PENDING, 32'h0000_0002);
        wr(`EEEC_OFF_PENDING, 32'h0000_0002);
        // Internal sources on lines 16 to 18 react to both edges.
        for (int k = 0; k < 3; k++) begin
            i_src.set_lvl(80 + k, 1);
            wait_evt(16 + k, 1, 1);
            i_src.set_lvl(80 + k, 0);
            wait_evt(16 + k, 1, 1);
            rd(`EEEC_OFF_PENDING, 32'h1 << (16 + k));
            wr(`EEEC_OFF_PENDING, 32'h1 << (16 + k));
        end
        wr(`EEEC_OFF_SW_TRIG, 32'h0000_0020);
        wait_evt(5, 1, 1);
        rd(`EEEC_OFF_PENDING, 32'h0000_0020);
        rd(`EEEC_OFF_SW_TRIG, 32'h0000_0020);
        wr(`EEEC_OFF_PENDING, 32'h0000_0020);
        rd(`EEEC_OFF_SW_TRIG, 32'h0000_0000);
        // A second reset in mid-run restores the reset values.
        i_src.pulse(37, 2.0);
        repeat (8) @(posedge clk);
        rst_b <= 0;
        repeat (4) @(posedge clk);
        rst_b <= 1;
        rd(`EEEC_OFF_PENDING, 32'h0000_0000);
        rd(`EEEC_OFF_SEL_BASE, 32'h7f7f_7f7f);
        chk_irq(0);
        test_done();
    end
endmodule
